/* File: rtl/pcsc_regs.vh */
// register offsets, field positions and the control register reset value for the clock select control
`ifndef PCSC_REGS_VH
`define PCSC_REGS_VH
`define PCSC_CTRL_OFS 12'h000
`define PCSC_STAT_OFS 12'h004
`define PCSC_ENV_OFS 12'h008
`define PCSC_ENV_EXTCLK_BIT 0
`define PCSC_ENV_STOP_BIT 1
`define PCSC_ENV_LOST_BIT 2
`define PCSC_ENV_LOSTOSC_BIT 3
`define PCSC_ENV_GATED_BIT 4
`define PCSC_ENV_RSTHOLD_BIT 5
`define PCSC_CTRL_SYNTH_ENABLE_BIT 0
`define PCSC_CTRL_MODE_BIT 1
`define PCSC_CTRL_SRC_BIT 2
`define PCSC_CTRL_FWK_BIT 5
`define PCSC_CTRL_WMASK 16'hFFE7
`define PCSC_CTRL_RST 16'h0002
`define PCSC_STAT_EXT_OSCILLATOR_SOURCE_FLAG_BIT 7
`define PCSC_STAT_LOCK_BIT 3
`endif

/* File: rtl/pcsc_top.v */
// pll clock source select, wakeup gating and lock reset hold, with ahb-lite slave
`timescale 1ns/100ps
`include "pcsc_regs.vh"

// What this block does
// - with fast wakeup clear, system clocks leave stop only once the pll locks, or at once if it is off, in external clock mode or a clock was lost in stop.
// - with fast wakeup set, system clocks come back from stop at once, lock or not.
// - with fast wakeup clear and a clock lost in stop, wake in self-clocked or reference mode.
// - in external clock mode fast wakeup has no effect on the stop wakeup.
// - control bit 2 picks the reference clock (0) or the pll output (1) when the pll is on and not in external clock mode.
// - while the pll is off the source select is ignored and the reference clock is used.
// - control bit 0 enables the pll when 1 and disables it when 0.
// - with the pll enabled out of reset and not in external clock mode, reset is held until lock and the pll drives the clock.
// - the status register reads at any time; writes to it change nothing and complete normally.
// - the status reset value comes from the reset configuration, not a constant.
// - status bit 7 reads 1 when an external oscillator supplies the reference clock.
// - the pll counts as locked within about 0.75% and loses lock beyond about 1.5%.
module pcsc_top (
   input wire hclk,
   input wire hresetn,
   input wire hsel,
   input wire [31:0] haddr,
   input wire [1:0] htrans,
   input wire hwrite,
   input wire [2:0] hsize,
   input wire [31:0] hwdata,
   input wire hready,
   output wire hreadyout,
   output wire hresp,
   output reg [31:0] hrdata,
   input wire cfg_pll_enable,
   input wire cfg_ext_oscillator,
   input wire cfg_ext_clock_mode,
   input wire pll_lock,
   input wire stop_mode,
   input wire pll_clock_lost,
   input wire osc_clock_lost,
   output reg synth_enable_out,
   output reg select_pll_clock,
   output reg system_clock_enable,
   output reg self_clocked_mode,
   output reg chip_reset_hold_n
);

// ---------------------------------------------
// bus slave
// ---------------------------------------------
reg [15:0] synth_control_reg_r;
reg [7:0] synth_status_reg_r;
reg cfg_taken_r;
reg wr_pend_r;
reg [11:0] wr_addr_r;
reg stop_r;
reg lost_pll_r;
reg lost_osc_r;
reg wake_wait_r;

wire access_ok = hsel && hready && htrans[1];
wire [11:0] addr_w = haddr[11:0];

assign hreadyout = 1'b1;
assign hresp = 1'b0;

function [31:0] rd_mux;
   input [11:0] a;
   begin
      if (a == `PCSC_CTRL_OFS) begin
         rd_mux = {16'h0000, synth_control_reg_r};
      end else if (a == `PCSC_STAT_OFS) begin
         rd_mux = {24'h00_0000, synth_status_reg_r};
      end else if (a == `PCSC_ENV_OFS) begin
         rd_mux = {26'h000_0000, ~chip_reset_hold_n, system_clock_enable,
                   lost_osc_r, lost_pll_r, stop_r, cfg_ext_clock_mode};
      end else begin
         rd_mux = 32'h0000_0000;
      end
   end
endfunction

always @(posedge hclk or negedge hresetn) begin
   if (!hresetn) begin
      wr_pend_r <= 1'b0;
      wr_addr_r <= 12'h000;
      hrdata <= 32'h0000_0000;
   end else begin
      wr_pend_r <= access_ok && hwrite;
      if (access_ok) begin
         wr_addr_r <= addr_w;
      end
      if (access_ok && !hwrite) begin
         hrdata <= rd_mux(addr_w);
      end
   end
end

// ---------------------------------------------
// control register
// ---------------------------------------------
// reserved bits 4..3 are held at zero whatever software writes
always @(posedge hclk or negedge hresetn) begin
   if (!hresetn) begin
      synth_control_reg_r <= `PCSC_CTRL_RST;
      cfg_taken_r <= 1'b0;
   end else begin
      cfg_taken_r <= 1'b1;
      if (!cfg_taken_r) begin
         synth_control_reg_r[`PCSC_CTRL_SYNTH_ENABLE_BIT] <= cfg_pll_enable;
         synth_control_reg_r[`PCSC_CTRL_SRC_BIT] <= cfg_pll_enable;
      end else if (wr_pend_r && wr_addr_r == `PCSC_CTRL_OFS) begin
         synth_control_reg_r <= hwdata[15:0] & `PCSC_CTRL_WMASK;
      end
   end
end

// ---------------------------------------------
// status register
// ---------------------------------------------
// strap caught at the first edge after release; bus writes never reach it
always @(posedge hclk or negedge hresetn) begin
   if (!hresetn) begin
      synth_status_reg_r <= 8'h00;
   end else begin
      if (!cfg_taken_r) begin
         synth_status_reg_r[`PCSC_STAT_EXT_OSCILLATOR_SOURCE_FLAG_BIT] <= cfg_ext_oscillator;
      end
      // lock comes from the analog detector with its 0.75%/1.5% hysteresis
      synth_status_reg_r[`PCSC_STAT_LOCK_BIT] <= pll_lock && !cfg_ext_clock_mode;
   end
end

// ---------------------------------------------
// clock select, wakeup and reset hold
// ---------------------------------------------
wire pll_on = synth_control_reg_r[`PCSC_CTRL_SYNTH_ENABLE_BIT];
wire fast_wake_select = synth_control_reg_r[`PCSC_CTRL_FWK_BIT];
wire locked = pll_lock && pll_on;

always @(posedge hclk or negedge hresetn) begin
   if (!hresetn) begin
      stop_r <= 1'b0;
      lost_pll_r <= 1'b0;
      lost_osc_r <= 1'b0;
      wake_wait_r <= 1'b0;
      synth_enable_out <= 1'b0;
      select_pll_clock <= 1'b0;
      system_clock_enable <= 1'b0;
      self_clocked_mode <= 1'b0;
      chip_reset_hold_n <= 1'b0;
   end else begin
      stop_r <= stop_mode;
      synth_enable_out <= pll_on;
      // pll output only when enabled and selected; otherwise reference clock
      select_pll_clock <= pll_on &&
         synth_control_reg_r[`PCSC_CTRL_SRC_BIT] && !cfg_ext_clock_mode;
      // hold reset until lock whenever the pll was enabled at reset, except in external clock mode
      if (cfg_taken_r && (!pll_on || locked || cfg_ext_clock_mode)) begin
         chip_reset_hold_n <= 1'b1;
      end
      if (stop_mode) begin
         if (pll_clock_lost && pll_on) begin
            lost_pll_r <= 1'b1;
         end
         if (osc_clock_lost) begin
            lost_osc_r <= 1'b1;
         end
         system_clock_enable <= 1'b0;
         wake_wait_r <= 1'b1;
      end else if (wake_wait_r) begin
         if (cfg_ext_clock_mode || fast_wake_select) begin
            system_clock_enable <= 1'b1;
            wake_wait_r <= 1'b0;
         end else if (lost_pll_r || lost_osc_r) begin
            // pll loss falls back to self clocking, oscillator loss to reference
            self_clocked_mode <= lost_pll_r;
            select_pll_clock <= 1'b0;
            system_clock_enable <= 1'b1;
            wake_wait_r <= 1'b0;
            lost_pll_r <= 1'b0;
            lost_osc_r <= 1'b0;
         end else if (locked || !pll_on) begin
            system_clock_enable <= 1'b1;
            self_clocked_mode <= 1'b0;
            wake_wait_r <= 1'b0;
         end
      end else begin
         system_clock_enable <= chip_reset_hold_n;
      end
   end
end

endmodule

/* File: tb/pcsc_top_properties.sv */
// concurrent checks on the pll clock select control ports
`timescale 1ns/100ps
module pcsc_props (
   input wire hclk,
   input wire hresetn,
   input wire hreadyout,
   input wire hresp,
   input wire cfg_pll_enable,
   input wire cfg_ext_clock_mode,
   input wire pll_lock,
   input wire stop_mode,
   input wire pll_clock_lost,
   input wire synth_enable_out,
   input wire select_pll_clock,
   input wire system_clock_enable,
   input wire self_clocked_mode,
   input wire chip_reset_hold_n
);
   default clocking @(posedge hclk); endclocking
   default disable iff (!hresetn);
   a_resp_okay: assert property (!hresp) else $error("bus response not okay");
   a_ready_high: assert property (hreadyout) else $error("bus cycle stalled");
   // enable and select outputs both register pll_on on the same edge; the check waits for two cycles of enable low
   a_off_ref_clock: assert property (!synth_enable_out [*2] |-> !select_pll_clock)
      else $error("pll clock used while pll off");
   a_hold_until_lock: assert property (cfg_pll_enable && !cfg_ext_clock_mode && !pll_lock
      && !chip_reset_hold_n |=> !chip_reset_hold_n) else $error("reset freed before lock");
   a_free_after_lock: assert property (cfg_pll_enable && pll_lock && !chip_reset_hold_n
      |=> chip_reset_hold_n) else $error("reset held after lock");
   a_release_on_pll: assert property ($rose(chip_reset_hold_n) && cfg_pll_enable
      && !cfg_ext_clock_mode |-> select_pll_clock) else $error("freed without pll clock");
   a_ext_wake: assert property ($fell(stop_mode) && cfg_ext_clock_mode
      |-> ##[1:2] system_clock_enable) else $error("slow wake in external mode");
   a_loss_wake: assert property ($fell(stop_mode) && pll_clock_lost && !cfg_ext_clock_mode
      |-> ##[1:2] system_clock_enable && self_clocked_mode) else $error("no self clocked wake");
endmodule

/* File: tb/tb_pcsc_top.sv */
// self-checking bench for the pll clock select control block
`timescale 1ns/100ps
module tb_pcsc_top;
   logic hclk = 1'h0, hresetn = 1'h0, hsel = 1'h0, hwrite = 1'h0, hready, hresp;
   logic cfg_pll_enable = 1'h1, cfg_ext_oscillator = 1'h1, cfg_ext_clock_mode = 1'h0;
   logic pll_lock = 1'h0, stop_mode = 1'h0, pll_clock_lost = 1'h0, chip_reset_hold_n;
   logic osc_clock_lost = 1'h0;
   logic synth_enable_out, select_pll_clock, system_clock_enable, self_clocked_mode;
   logic [1:0] htrans = 2'h0;
   logic [31:0] haddr = 32'h0000_0000, hwdata = 32'h0000_0000, hrdata, rd;
   logic [7:0] ctl[5] = '{8'h03, 8'h02, 8'h06, 8'h03, 8'h27};
   int err_total = 0, n_checks = 0;
   pcsc_top i_pcsc_top (.*, .hsize(3'h2), .hreadyout(hready));
   always #2.5 hclk = ~hclk;
   task chk(input string nm, input [31:0] e, g);
      n_checks++;
      err_total += (g !== e);
      if (g !== e) $display("CHECK FAILED %s expected %h seen %h", nm, e, g);
   endtask
   task xfer(input logic w, input [7:0] a, d);
      {hsel, hwrite, haddr, htrans} <= {1'h1, w, 24'h00_0000, a, 2'h2};
      do @(posedge hclk); while (hready !== 1'h1);
      {htrans, hwdata} <= {2'h0, 24'h00_0000, d};
      do @(posedge hclk); while (hready !== 1'h1);
      rd = hrdata;
   endtask
   task stop_cycle;
      stop_mode <= 1'h1;
      repeat (4) @(posedge hclk);
      stop_mode <= 1'h0;
      repeat (4) @(posedge hclk);
   endtask
   task tally_and_finish;
      $display("checks %0d mismatches %0d", n_checks, err_total);
      if (err_total == 0 && n_checks > 0)
         $display("ALL TESTS PASSED");
      else
         $display("TESTS FAILED");
      $finish;
   endtask
   initial begin
      #20000 err_total++;
      tally_and_finish;
   end
   initial begin
      repeat (20) @(posedge hclk);
      hresetn <= 1'h1;
      repeat (5) @(posedge hclk);
      chk("reset hold", 8'h00, chip_reset_hold_n);
      pll_lock <= 1'h1;
      repeat (3) @(posedge hclk);
      chk("pll release", 8'h01, select_pll_clock & chip_reset_hold_n);
      xfer(1'h1, 8'h04, 8'h00);
      xfer(1'h0, 8'h04, 8'h00);
      chk("status", 8'h88, rd);
      xfer(1'h1, 8'h00, 8'h1f);
      xfer(1'h0, 8'h00, 8'h00);
      chk("control", 8'h07, rd);
      xfer(1'h0, 8'h40, 8'h00);
      chk("unmapped", 8'h00, rd);
      // switch back before disabling, select while off to see it ignored, then enable before selecting the pll
      foreach (ctl[i]) begin
         xfer(1'h1, 8'h00, ctl[i]);
         repeat (3) @(posedge hclk);
         chk("enable", ctl[i][0], synth_enable_out);
         chk("pll select", ctl[i][0] & ctl[i][2], select_pll_clock);
      end
      $display("test registers done");
      pll_lock <= 1'h0;
      stop_cycle;
      chk("fast wake", 8'h01, system_clock_enable);
      xfer(1'h1, 8'h00, 8'h07);
      stop_cycle;
      chk("locked wake", 8'h00, system_clock_enable);
      cfg_ext_clock_mode <= 1'h1;
      stop_cycle;
      chk("external wake", 8'h01, system_clock_enable);
      {cfg_ext_clock_mode, pll_clock_lost} <= 2'h1;
      stop_cycle;
      chk("loss wake", 8'h01, self_clocked_mode & system_clock_enable);
      // oscillator loss wakes on the reference clock, not self clocked
      {pll_clock_lost, osc_clock_lost} <= 2'h1;
      stop_cycle;
      chk("osc loss wake", 8'h01, ~self_clocked_mode & system_clock_enable);
      osc_clock_lost <= 1'h0;
      xfer(1'h0, 8'h08, 8'h00);
      chk("environment", 8'h10, rd);
      $display("test wakeup done");
      tally_and_finish;
   end
endmodule
bind pcsc_top pcsc_props i_pcsc_props (.*);
